/* File: design/iopf_consts.svh */
// Register offsets, field positions, key and reset values
`ifndef IOPF_CONSTS_SVH
`define IOPF_CONSTS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define IOPF_OFF_FLT_SLOW_DIS 32'hfffff480
`define IOPF_OFF_FLT_SLOW_ENA 32'hfffff484
`define IOPF_OFF_FLT_CHOICE 32'hfffff488
`define IOPF_OFF_DEB_DIV 32'hfffff48c
`define IOPF_OFF_PD_DIS 32'hfffff490
`define IOPF_OFF_PD_ENA 32'hfffff494
`define IOPF_OFF_PD_STATE 32'hfffff498
`define IOPF_OFF_OWG_ENA 32'hfffff4a0
`define IOPF_OFF_OWG_DIS 32'hfffff4a4
`define IOPF_OFF_OWG_STATE 32'hfffff4a8
`define IOPF_OFF_XIM_ENA 32'hfffff4b0
`define IOPF_OFF_XIM_DIS 32'hfffff4b4
`define IOPF_OFF_XIM_STATE 32'hfffff4b8
`define IOPF_OFF_EDGE_SEL 32'hfffff4c0
`define IOPF_OFF_LEVEL_SEL 32'hfffff4c4
`define IOPF_OFF_EL_STATE 32'hfffff4c8
`define IOPF_OFF_FALL_SEL 32'hfffff4d0
`define IOPF_OFF_RISE_SEL 32'hfffff4d4
`define IOPF_OFF_FR_STATE 32'hfffff4d8
`define IOPF_OFF_WP_MODE 32'hfffff4e4
`define IOPF_OFF_IRQ_STATUS 32'hfffff4f0
`define IOPF_OFF_IRQ_MASK 32'hfffff4f4

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define IOPF_DIV_W 14
`define IOPF_WP_EN_BIT 0
`define IOPF_WP_KEY_LSB 8
`define IOPF_WP_KEY 24'h50494f
`define IOPF_RST_LINES 32'h00000000
`define IOPF_RST_DIV 14'h0000

`endif

/* File: design/iopf_pkg.sv */
// Types shared by the I/O line pull-down, filter and interrupt mode block
package iopf_pkg;

   // Register bus request from software
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } iopf_bus_req_t;

   // Output data write from the rest of the controller
   typedef struct packed {
      logic [31:0] data;
      logic wr;
   } iopf_odata_wr_t;

   // Interrupt source kinds of one line
   typedef enum logic [1:0] {
      IOPF_SRC_BOTH = 2'b00,
      IOPF_SRC_EDGE = 2'b01,
      IOPF_SRC_LEVEL = 2'b10
   } iopf_src_t;

endpackage : iopf_pkg

/* File: design/iopf_core.sv */
// Pull-down, input filter, output write gate and interrupt mode block
`timescale 1ns/1ps
`include "iopf_consts.svh"

module iopf_core
   import iopf_pkg::*;
(
   input wire logic clk, // 250 MHz peripheral clock
   input wire logic sys_rst, // Asynchronous reset, active high
   input wire iopf_bus_req_t bus_req, // Register bus request
   output logic [31:0] bus_rdata, // Read data, cycle after read strobe
   input wire iopf_odata_wr_t odata_wr, // Output data register write
   input wire logic [31:0] pin_in, // Raw line levels
   input wire logic slow_clk_in, // Slow clock, sampled as a level
   output logic [31:0] out_level, // Output data levels
   output logic [31:0] pad_pulldown_on, // Pad pull-down enables
   output logic [31:0] filt_level, // Filtered line levels
   output logic irq // Level interrupt
);

   // ****************************************************************
   // Register bus decode
   // ****************************************************************
   function automatic logic wr_hit(input iopf_bus_req_t r, input logic [31:0] off);
      wr_hit = r.wr && (r.addr == off);
   endfunction : wr_hit

   // Per-line interrupt event from mode, edge/level and polarity
   function automatic logic [31:0] line_event(input logic [31:0] aim, input logic [31:0] lvl,
                                               input logic [31:0] rise, input logic [31:0] cur,
                                               input logic [31:0] prev);
      line_event = (~aim & (cur ^ prev))
                 | (aim & lvl & ~(cur ^ rise))
                 | (aim & ~lvl & rise & cur & ~prev)
                 | (aim & ~lvl & ~rise & ~cur & prev);
   endfunction : line_event

   logic [31:0] flt_sel_reg;
   logic [`IOPF_DIV_W-1:0] div_reg;
   logic [31:0] pd_on_reg;
   logic [31:0] owg_reg;
   logic [31:0] aim_reg;
   logic [31:0] lvl_reg;
   logic [31:0] rise_reg;
   logic wp_en_reg;
   logic [31:0] out_reg;
   logic [31:0] irq_stat_reg;
   logic [31:0] irq_stat_next;
   logic [31:0] irq_mask_reg;
   logic [31:0] irq_mask_next;
   logic irq_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic wp_open;
   logic key_ok;

   assign wp_open = ~wp_en_reg;
   assign key_ok = bus_req.wdata[31:`IOPF_WP_KEY_LSB] == `IOPF_WP_KEY;

   // ****************************************************************
   // Write protection
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         wp_en_reg <= 1'b0;
      else if (wr_hit(bus_req, `IOPF_OFF_WP_MODE) && key_ok)
         wp_en_reg <= bus_req.wdata[`IOPF_WP_EN_BIT];
   end

   // ****************************************************************
   // Pad pull-down
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pd_on_reg <= `IOPF_RST_LINES;
      else if (wp_open && wr_hit(bus_req, `IOPF_OFF_PD_ENA))
         pd_on_reg <= pd_on_reg | bus_req.wdata;
      else if (wp_open && wr_hit(bus_req, `IOPF_OFF_PD_DIS))
         pd_on_reg <= pd_on_reg & ~bus_req.wdata;
   end

   // ****************************************************************
   // Output write gate and output data
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         owg_reg <= `IOPF_RST_LINES;
      else if (wp_open && wr_hit(bus_req, `IOPF_OFF_OWG_ENA))
         owg_reg <= owg_reg | bus_req.wdata;
      else if (wp_open && wr_hit(bus_req, `IOPF_OFF_OWG_DIS))
         owg_reg <= owg_reg & ~bus_req.wdata;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         out_reg <= `IOPF_RST_LINES;
      else if (odata_wr.wr)
         out_reg <= (out_reg & ~owg_reg) | (odata_wr.data & owg_reg);
   end

   // ****************************************************************
   // Filter choice and divider setting
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         flt_sel_reg <= `IOPF_RST_LINES;
      else if (wr_hit(bus_req, `IOPF_OFF_FLT_SLOW_ENA))
         flt_sel_reg <= flt_sel_reg | bus_req.wdata;
      else if (wr_hit(bus_req, `IOPF_OFF_FLT_SLOW_DIS))
         flt_sel_reg <= flt_sel_reg & ~bus_req.wdata;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         div_reg <= `IOPF_RST_DIV;
      else if (wr_hit(bus_req, `IOPF_OFF_DEB_DIV))
         div_reg <= bus_req.wdata[`IOPF_DIV_W-1:0];
   end

   // ****************************************************************
   // Interrupt mode selections
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         aim_reg <= `IOPF_RST_LINES;
      else if (wr_hit(bus_req, `IOPF_OFF_XIM_ENA))
         aim_reg <= aim_reg | bus_req.wdata;
      else if (wr_hit(bus_req, `IOPF_OFF_XIM_DIS))
         aim_reg <= aim_reg & ~bus_req.wdata;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         lvl_reg <= `IOPF_RST_LINES;
      else if (wr_hit(bus_req, `IOPF_OFF_EDGE_SEL))
         lvl_reg <= lvl_reg & ~bus_req.wdata;
      else if (wr_hit(bus_req, `IOPF_OFF_LEVEL_SEL))
         lvl_reg <= lvl_reg | bus_req.wdata;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         rise_reg <= `IOPF_RST_LINES;
      else if (wr_hit(bus_req, `IOPF_OFF_RISE_SEL))
         rise_reg <= rise_reg | bus_req.wdata;
      else if (wr_hit(bus_req, `IOPF_OFF_FALL_SEL))
         rise_reg <= rise_reg & ~bus_req.wdata;
   end

   // ****************************************************************
   // Slow clock divider
   // ****************************************************************
   logic slck_q_reg;
   logic slck_rise;
   logic [`IOPF_DIV_W-1:0] dcnt_reg;
   logic half_tick_reg;

   assign slck_rise = slow_clk_in & ~slck_q_reg;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         slck_q_reg <= 1'b0;
      else
         slck_q_reg <= slow_clk_in;
   end

   // Half of the divided period is div+1 slow cycles
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dcnt_reg <= `IOPF_RST_DIV;
         half_tick_reg <= 1'b0;
      end
      else
      begin
         half_tick_reg <= slck_rise && (dcnt_reg >= div_reg);
         if (slck_rise)
            dcnt_reg <= (dcnt_reg >= div_reg) ? `IOPF_RST_DIV : dcnt_reg + 1'b1;
      end
   end

   // ****************************************************************
   // Glitch and debounce filters
   // ****************************************************************
   logic [31:0] gl_samp_reg;
   logic [31:0] gl_val_reg;
   logic [31:0] deb_samp_reg;
   logic [31:0] deb_val_reg;
   logic [31:0] filt_reg;
   logic [31:0] filt_prev_reg;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gl_samp_reg <= `IOPF_RST_LINES;
         gl_val_reg <= `IOPF_RST_LINES;
      end
      else
      begin
         gl_samp_reg <= pin_in;
         // A level must hold across two samples to pass
         gl_val_reg <= (gl_val_reg & (pin_in ^ gl_samp_reg))
                     | (pin_in & ~(pin_in ^ gl_samp_reg));
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         deb_samp_reg <= `IOPF_RST_LINES;
         deb_val_reg <= `IOPF_RST_LINES;
      end
      else if (half_tick_reg)
      begin
         deb_samp_reg <= pin_in;
         deb_val_reg <= (deb_val_reg & (pin_in ^ deb_samp_reg))
                      | (pin_in & ~(pin_in ^ deb_samp_reg));
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         filt_reg <= `IOPF_RST_LINES;
         filt_prev_reg <= `IOPF_RST_LINES;
      end
      else
      begin
         filt_reg <= (deb_val_reg & flt_sel_reg) | (gl_val_reg & ~flt_sel_reg);
         filt_prev_reg <= filt_reg;
      end
   end

   // ****************************************************************
   // Interrupt status, mask and output
   // ****************************************************************
   logic [31:0] evt;
   logic [31:0] stat_clr;

   assign evt = line_event(aim_reg, lvl_reg, rise_reg, filt_reg, filt_prev_reg);
   assign stat_clr = wr_hit(bus_req, `IOPF_OFF_IRQ_STATUS) ? bus_req.wdata : 32'h00000000;
   // A new event wins over a clear in the same cycle
   assign irq_stat_next = (irq_stat_reg & ~stat_clr) | evt;
   assign irq_mask_next = wr_hit(bus_req, `IOPF_OFF_IRQ_MASK) ? bus_req.wdata : irq_mask_reg;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         irq_stat_reg <= `IOPF_RST_LINES;
      else
         irq_stat_reg <= irq_stat_next;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         irq_mask_reg <= `IOPF_RST_LINES;
      else
         irq_mask_reg <= irq_mask_next;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(irq_stat_next & irq_mask_next);
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   always_comb
   begin
      rdata_next = 32'h00000000;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            `IOPF_OFF_FLT_CHOICE: rdata_next = flt_sel_reg;
            `IOPF_OFF_DEB_DIV: rdata_next = {{(32-`IOPF_DIV_W){1'b0}}, div_reg};
            `IOPF_OFF_PD_STATE: rdata_next = ~pd_on_reg;
            `IOPF_OFF_OWG_STATE: rdata_next = owg_reg;
            `IOPF_OFF_XIM_STATE: rdata_next = aim_reg;
            `IOPF_OFF_EL_STATE: rdata_next = lvl_reg;
            `IOPF_OFF_FR_STATE: rdata_next = rise_reg;
            `IOPF_OFF_WP_MODE: rdata_next = {31'h00000000, wp_en_reg};
            `IOPF_OFF_IRQ_STATUS: rdata_next = irq_stat_reg;
            `IOPF_OFF_IRQ_MASK: rdata_next = irq_mask_reg;
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         rdata_reg <= 32'h00000000;
      else
         rdata_reg <= rdata_next;
   end

   assign bus_rdata = rdata_reg;
   assign out_level = out_reg;
   assign pad_pulldown_on = pd_on_reg;
   assign filt_level = filt_reg;
   assign irq = irq_reg;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   pd_enable_a: assert property (
      (wp_open && wr_hit(bus_req, `IOPF_OFF_PD_ENA)) |=> ((pd_on_reg & $past(bus_req.wdata))
         == $past(bus_req.wdata)))
      else $error("pull-down enable write did not take");

   pd_disable_a: assert property (
      (wp_open && wr_hit(bus_req, `IOPF_OFF_PD_DIS)) |=> ((pd_on_reg & $past(bus_req.wdata))
         == 32'h00000000))
      else $error("pull-down disable write did not take");

   wp_guard_a: assert property (
      (wp_en_reg && bus_req.wr && (bus_req.addr >= `IOPF_OFF_PD_DIS)
         && (bus_req.addr <= `IOPF_OFF_OWG_DIS)) |=> ($stable(pd_on_reg) && $stable(owg_reg)))
      else $error("protected register changed while protection is on");

   wp_key_a: assert property (
      (wr_hit(bus_req, `IOPF_OFF_WP_MODE) && !key_ok) |=> $stable(wp_en_reg))
      else $error("protection bit changed with a wrong key");

   gate_block_a: assert property (
      odata_wr.wr |=> (((out_reg ^ $past(out_reg)) & ~$past(owg_reg)) == 32'h00000000))
      else $error("output changed on a gated-off line");

   gate_pass_a: assert property (
      odata_wr.wr |=> ((out_reg & $past(owg_reg)) == ($past(odata_wr.data) & $past(owg_reg))))
      else $error("output write did not reach an open line");

   pd_read_a: assert property (
      (bus_req.rd && bus_req.addr == `IOPF_OFF_PD_STATE) |=> (bus_rdata == ~$past(pd_on_reg)))
      else $error("pull-down state read wrong");

   both_edge_a: assert property (
      ((filt_reg ^ filt_prev_reg) & ~aim_reg) != 32'h00000000 |=>
         ((irq_stat_reg & $past((filt_reg ^ filt_prev_reg) & ~aim_reg))
         == $past((filt_reg ^ filt_prev_reg) & ~aim_reg)))
      else $error("both-edge event lost");

   div_tick_a: assert property (
      (slck_rise && dcnt_reg >= div_reg) |=> (half_tick_reg && dcnt_reg == `IOPF_RST_DIV))
      else $error("divider half period wrong");

   irq_out_a: assert property (
      |(irq_stat_reg & irq_mask_reg) |-> irq_reg)
      else $error("interrupt low with unmasked status set");

   cover_pd_on_c: cover property (wr_hit(bus_req, `IOPF_OFF_PD_ENA) && wp_open ##1 |pd_on_reg);
   cover_wp_block_c: cover property (wp_en_reg && wr_hit(bus_req, `IOPF_OFF_OWG_ENA));
   cover_level_irq_c: cover property (|(aim_reg & lvl_reg) ##1 irq_reg);
   cover_deb_c: cover property (half_tick_reg && |flt_sel_reg);

endmodule : iopf_core

/* File: verif/tb_iopf_core.sv */
// Self-checking testbench for the pull-down, filter and interrupt mode block
`timescale 1ns/1ps
`include "iopf_consts.svh"

`define CHK(nm, ex, gt) \
   begin \
      compares++; \
      if ((gt) !== (ex)) \
      begin \
         fail_count++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); \
      end \
   end

module tb_iopf_core
   import iopf_pkg::*;
;
   logic clk;
   logic sys_rst;
   iopf_bus_req_t bus_req;
   iopf_odata_wr_t odata_wr;
   logic [31:0] pin_in;
   logic slow_clk_in = 1'b0;
   logic [31:0] bus_rdata;
   logic [31:0] out_level;
   logic [31:0] pad_pulldown_on;
   logic [31:0] filt_level;
   logic irq;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   integer seed = 32700;
   logic [31:0] pd, gate, outv, rv, a, b;
   logic seen;

   iopf_core iopf_core_i (
      .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .odata_wr(odata_wr), .pin_in(pin_in), .slow_clk_in(slow_clk_in),
      .out_level(out_level), .pad_pulldown_on(pad_pulldown_on),
      .filt_level(filt_level), .irq(irq)
   );

   // ****************************************************************
   // Clock, slow clock and timeout
   // ****************************************************************
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles % 4 == 0)
         slow_clk_in <= ~slow_clk_in;
      if (cycles == 20000)
      begin
         fail_count++;
         end_of_test();
      end
   end

   // ****************************************************************
   // Bus tasks and expectation functions
   // ****************************************************************
   task automatic wr_reg(input logic [31:0] ad, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req <= '{addr: ad, wdata: d, wr: 1'b0, rd: 1'b0};
   endtask : wr_reg

   task automatic rd_reg(input logic [31:0] ad, output logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
      #1 d = bus_rdata;
   endtask : rd_reg

   function automatic logic [31:0] gated(input logic [31:0] o, input logic [31:0] d,
                                         input logic [31:0] g);
      return (o & ~g) | (d & g);
   endfunction : gated

   task automatic wait_irq(input logic want);
      seen = 1'b0;
      repeat (12)
      begin
         @(posedge clk);
         #1 if (irq === want) seen = 1'b1;
      end
   endtask : wait_irq

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      sys_rst = 1'b1;
      bus_req = '0;
      odata_wr = '0;
      pin_in = 32'h0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd_reg(`IOPF_OFF_PD_STATE, rv);
      `CHK("pd_state_rst", 32'hffffffff, rv)
      rd_reg(`IOPF_OFF_OWG_STATE, rv);
      `CHK("gate_rst", 32'h00000000, rv)
      rd_reg(`IOPF_OFF_XIM_STATE, rv);
      `CHK("xim_rst", 32'h00000000, rv)
      rd_reg(`IOPF_OFF_FLT_CHOICE, rv);
      `CHK("filter_rst", 32'h00000000, rv)
      rd_reg(32'hfffff4fc, rv);
      `CHK("unmapped", 32'h00000000, rv)
      pd = 32'h0;
      gate = 32'h0;
      outv = 32'h0;
      // Random pull-down and gate traffic against a bench model
      repeat (8)
      begin
         a = $random(seed);
         b = $random(seed);
         wr_reg(`IOPF_OFF_PD_ENA, a);
         wr_reg(`IOPF_OFF_PD_DIS, b);
         pd = (pd | a) & ~b;
         rd_reg(`IOPF_OFF_PD_STATE, rv);
         `CHK("pd_state", ~pd, rv)
         `CHK("pad_pd", pd, pad_pulldown_on)
         wr_reg(`IOPF_OFF_OWG_ENA, b);
         wr_reg(`IOPF_OFF_OWG_DIS, a);
         gate = (gate | b) & ~a;
         rd_reg(`IOPF_OFF_OWG_STATE, rv);
         `CHK("gate_state", gate, rv)
         a = $random(seed);
         @(posedge clk);
         odata_wr <= '{data: a, wr: 1'b1};
         @(posedge clk);
         odata_wr <= '{data: a, wr: 1'b0};
         outv = gated(outv, a, gate);
         #1 `CHK("out_level", outv, out_level)
      end
      // Divider field read back
      a = $random(seed);
      wr_reg(`IOPF_OFF_DEB_DIV, a);
      rd_reg(`IOPF_OFF_DEB_DIV, rv);
      `CHK("divider", {18'h0, a[13:0]}, rv)
      // Protection: wrong key refused, right key blocks pull-down and gate writes
      wr_reg(`IOPF_OFF_WP_MODE, 32'h12345601);
      wr_reg(`IOPF_OFF_PD_ENA, 32'h80000000);
      pd = pd | 32'h80000000;
      rd_reg(`IOPF_OFF_WP_MODE, rv);
      `CHK("wp_badkey", 32'h00000000, rv)
      wr_reg(`IOPF_OFF_WP_MODE, {`IOPF_WP_KEY, 8'h01});
      wr_reg(`IOPF_OFF_PD_DIS, 32'hffffffff);
      wr_reg(`IOPF_OFF_OWG_ENA, 32'hffffffff);
      rd_reg(`IOPF_OFF_PD_STATE, rv);
      `CHK("pd_locked", ~pd, rv)
      rd_reg(`IOPF_OFF_OWG_STATE, rv);
      `CHK("gate_locked", gate, rv)
      wr_reg(`IOPF_OFF_WP_MODE, {`IOPF_WP_KEY, 8'h00});
      wr_reg(`IOPF_OFF_PD_DIS, 32'hffffffff);
      rd_reg(`IOPF_OFF_PD_STATE, rv);
      `CHK("pd_unlocked", 32'hffffffff, rv)
      // Both-edge interrupt on line 0
      wr_reg(`IOPF_OFF_IRQ_MASK, 32'h00000001);
      @(posedge clk);
      pin_in <= 32'h00000001;
      wait_irq(1'b1);
      `CHK("irq_both_rise", 1'b1, seen)
      rd_reg(`IOPF_OFF_IRQ_STATUS, rv);
      `CHK("status0", 1'b1, rv[0])
      wr_reg(`IOPF_OFF_IRQ_STATUS, 32'h00000001);
      wait_irq(1'b0);
      `CHK("irq_clear", 1'b1, seen)
      // Programmed rising edge: falling must stay quiet
      wr_reg(`IOPF_OFF_EDGE_SEL, 32'h00000001);
      wr_reg(`IOPF_OFF_RISE_SEL, 32'h00000001);
      wr_reg(`IOPF_OFF_XIM_ENA, 32'h00000001);
      rd_reg(`IOPF_OFF_XIM_STATE, rv);
      `CHK("xim_on", 32'h00000001, rv)
      rd_reg(`IOPF_OFF_FR_STATE, rv);
      `CHK("rise_state", 32'h00000001, rv)
      rd_reg(`IOPF_OFF_EL_STATE, rv);
      `CHK("edge_state", 32'h00000000, rv)
      @(posedge clk);
      pin_in <= 32'h00000000;
      wait_irq(1'b1);
      `CHK("irq_fall_quiet", 1'b0, seen)
      @(posedge clk);
      pin_in <= 32'h00000001;
      wait_irq(1'b1);
      `CHK("irq_rise", 1'b1, seen)
      // Low level: status re-sets while the level holds
      wr_reg(`IOPF_OFF_LEVEL_SEL, 32'h00000001);
      wr_reg(`IOPF_OFF_FALL_SEL, 32'h00000001);
      wr_reg(`IOPF_OFF_IRQ_STATUS, 32'h00000001);
      wait_irq(1'b1);
      `CHK("irq_high_quiet", 1'b0, seen)
      @(posedge clk);
      pin_in <= 32'h00000000;
      wait_irq(1'b1);
      `CHK("irq_low", 1'b1, seen)
      wr_reg(`IOPF_OFF_IRQ_STATUS, 32'h00000001);
      rd_reg(`IOPF_OFF_IRQ_STATUS, rv);
      `CHK("level_reset", 1'b1, rv[0])
      wr_reg(`IOPF_OFF_XIM_DIS, 32'h00000001);
      rd_reg(`IOPF_OFF_XIM_STATE, rv);
      `CHK("xim_off", 32'h00000000, rv)
      // Debounce on line 1 with divider 1
      wr_reg(`IOPF_OFF_DEB_DIV, 32'h00000001);
      wr_reg(`IOPF_OFF_FLT_SLOW_ENA, 32'h00000002);
      rd_reg(`IOPF_OFF_FLT_CHOICE, rv);
      `CHK("filter_sel", 32'h00000002, rv)
      @(posedge clk);
      pin_in <= 32'h00000002;
      repeat (2) @(posedge clk);
      pin_in <= 32'h00000000;
      wait_irq(1'b1);
      seen = 1'b0;
      repeat (60)
      begin
         @(posedge clk);
         #1 if (filt_level[1] === 1'b1) seen = 1'b1;
      end
      `CHK("short_pulse", 1'b0, seen)
      @(posedge clk);
      pin_in <= 32'h00000002;
      seen = 1'b0;
      repeat (200)
      begin
         @(posedge clk);
         #1 if (filt_level[1] === 1'b1) seen = 1'b1;
      end
      `CHK("long_level", 1'b1, seen)
      // Back to the glitch filter; a one-cycle pulse on line 2 is dropped
      wr_reg(`IOPF_OFF_FLT_SLOW_DIS, 32'h00000002);
      rd_reg(`IOPF_OFF_FLT_CHOICE, rv);
      `CHK("filter_off", 32'h00000000, rv)
      @(posedge clk);
      pin_in <= 32'h00000006;
      @(posedge clk);
      pin_in <= 32'h00000002;
      seen = 1'b0;
      repeat (8)
      begin
         @(posedge clk);
         #1 if (filt_level[2] === 1'b1) seen = 1'b1;
      end
      `CHK("glitch_drop", 1'b0, seen)
      end_of_test();
   end
endmodule : tb_iopf_core
